// *** src/sad_regs.vh ***
// address map constants and configuration offsets for the system address decoder
`ifndef SAD_REGS_VH
`define SAD_REGS_VH

// widths
`define SAD_AW          36
`define SAD_BEW         8
`define SAD_DEST_W      3

// configuration offsets
`define CFG_AP_BASE_LO  8'h12
`define CFG_AP_BASE_HI  8'h13
`define CFG_HOLE_CTRL   8'h58
`define CFG_SHADOW_F    8'h59
`define CFG_SHADOW_E    8'h5A
`define CFG_AP_SIZE     8'hB4

// reset values and aperture size limit
`define HOLE_CTRL_RST   8'h00
`define SHADOW_RST      8'h00
`define AP_BASE_RST     10'h000
`define AP_SIZE_RST     3'h6
`define AP_SIZE_MAX     3'h6

// field positions
`define HOLE_EN_BIT     7
`define SHF_RE_BIT      0
`define SHF_WE_BIT      1

// destinations
`define DEST_DRAM       3'h0
`define DEST_HUBA       3'h1
`define DEST_HUBB       3'h2
`define DEST_GFX        3'h3
`define DEST_TERM       3'h4

// request sources
`define SRC_CPU         2'h0
`define SRC_HUBA        2'h1
`define SRC_HUBB        2'h2
`define SRC_GFX         2'h3

// fixed ranges, 4 GB boundary, minimum top SMRAM size and E segment index shift
`define A_DOS_HI        36'h0_0009_FFFF
`define A_VGA_LO        36'h0_000A_0000
`define A_VGA_HI        36'h0_000B_FFFF
`define A_ESEG_LO       36'h0_000E_0000
`define A_ESEG_HI       36'h0_000E_FFFF
`define A_FSEG_LO       36'h0_000F_0000
`define A_FSEG_HI       36'h0_000F_FFFF
`define A_HOLE_LO       36'h0_00F0_0000
`define A_HOLE_HI       36'h0_00FF_FFFF
`define A_HIGH_LO       36'h0_FFEA_0000
`define A_HIGH_HI       36'h0_FFEB_FFFF
`define A_APIC_LO       36'h0_FEC0_0000
`define A_APIC_MID      36'h0_FEC7_FFFF
`define A_APIC_HI       36'h0_FECF_FFFF
`define A_4G            36'h1_0000_0000
`define A_ZERO          36'h0_0000_0000
`define TOP_SMRAM_MIN   36'h0_0002_0000
`define ESEG_SHIFT      14

`endif

// *** src/window_match.v ***
// inclusive base/limit window comparator
`timescale 1ns/1ns
`default_nettype none
module window_match #(
  parameter AW = 36
) (
  // compare operands
  input  wire [AW-1:0] addr_i,
  input  wire [AW-1:0] base_i,
  input  wire [AW-1:0] limit_i,
  // result
  output wire          hit_o
);
  // bounds included on both ends
  assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule
`default_nettype wire

// *** src/system_address_decoder.v ***
// address classification and routing for processor, hub and graphics requests
`timescale 1ns/1ns
`default_nettype none
`include "sad_regs.vh"
// Overview of operation
// - E0000h-EFFFFh: four 16 KB segments, own read/write attributes, never remapped.
// - F0000h-FFFFFh one 64 KB segment, disabled after reset, goes to hub A.
// - hole enable at 58h sends 00F0_0000-00FF_FFFF to hub A.
// - enabled high SMRAM, SMM processor accesses remap to DRAM A0000h-BFFFFh.
// - non-SMM processor access to high SMRAM remaps to 0h, writes lose byte enables.
// - non-SMM write-back cycles to high or top SMRAM still reach SMM DRAM.
// - DRAM behind high SMRAM addresses is never reachable.
// - top SMRAM below top of memory; SMM processor accesses hit DRAM, others invalid.
// - top SMRAM size selectable 128 KB to 1 MB from top of DRAM.
// - hub and graphics initiators never reach enabled SMRAM.
// - only FEC0_0000h-FECF_FFFFh decoded: low half hub A, high half hub B.
// - hub B disabled sends upper APIC half to hub A; never graphics port.
// - hub I/O agents to APIC: reads master-abort, writes discarded.
// - graphics port claims memory or prefetchable base/limit windows, bounds included.
// - hub B memory and prefetchable windows route to hub B.
// - unmatched accesses between top of memory and 4 GB go to hub A.
// - aperture size 4-256 MB; matching low base bits read zero, not writable.
// - aperture size resets to 256 MB; range naturally aligned.
// - aperture accesses go to DRAM flagged for table translation.
// - accesses above 4 GB terminate: writes dropped, reads zero.
// - compatible SMRAM: SMM processor to DRAM; others treated as video buffer.
module system_address_decoder (
  // clock and reset
  input  wire                   sys_clk_i,
  input  wire                   rstn_i,
  // configuration access
  input  wire                   cfg_wr_i,
  input  wire                   cfg_rd_i,
  input  wire [7:0]             cfg_addr_i,
  input  wire [7:0]             cfg_wdata_i,
  output wire [7:0]             cfg_rdata_o,
  // memory map settings
  input  wire                   compatible_smram_en_i,
  input  wire                   high_smram_segment_en_i,
  input  wire                   top_smram_segment_en_i,
  input  wire [1:0]             top_smram_size_i,
  input  wire [31:0]            top_of_memory_i,
  input  wire                   hubb_en_i,
  input  wire                   aperture_en_i,
  input  wire [31:0]            gfx_mem_window_base_i,
  input  wire [31:0]            gfx_mem_window_limit_i,
  input  wire [31:0]            gfx_prefetch_window_base_i,
  input  wire [31:0]            gfx_prefetch_window_limit_i,
  input  wire [31:0]            hubb_mem_window_base_i,
  input  wire [31:0]            hubb_mem_window_limit_i,
  input  wire [31:0]            hubb_prefetch_window_base_i,
  input  wire [31:0]            hubb_prefetch_window_limit_i,
  // request
  input  wire                   req_valid_i,
  input  wire [`SAD_AW-1:0]     req_addr_i,
  input  wire [1:0]             req_src_i,
  input  wire                   req_write_i,
  input  wire                   req_smm_i,
  input  wire                   req_wb_i,
  input  wire [`SAD_BEW-1:0]    req_be_i,
  // routed result
  output wire                   rsp_valid_o,
  output wire [`SAD_DEST_W-1:0] rsp_dest_o,
  output wire [`SAD_AW-1:0]     rsp_addr_o,
  output wire [`SAD_BEW-1:0]    rsp_be_o,
  output wire                   rsp_xlate_o,
  output wire                   rsp_mabort_o,
  output wire                   rsp_rdzero_o,
  output wire                   rsp_drop_o
);

  function in_range;
    input [`SAD_AW-1:0] a;
    input [`SAD_AW-1:0] lo;
    input [`SAD_AW-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // low aperture base bits forced to zero for the chosen size
  function [9:0] ap_mask;
    input [2:0] sel;
    begin
      ap_mask = ~((10'h001 << sel) - 10'h001);
    end
  endfunction

  // configuration state
  reg  [7:0]            hole_ctrl_r;
  reg  [7:0]            shadow_e_r;
  reg  [7:0]            shadow_f_r;
  reg  [9:0]            ap_base_r;
  reg  [2:0]            ap_size_r;
  reg  [7:0]            cfg_rdata_r;
  reg  [7:0]            cfg_rdata_nxt;
  // result registers
  reg                   rsp_valid_r;
  reg  [`SAD_DEST_W-1:0] rsp_dest_r;
  reg  [`SAD_AW-1:0]    rsp_addr_r;
  reg  [`SAD_BEW-1:0]   rsp_be_r;
  reg                   rsp_xlate_r;
  reg                   rsp_mabort_r;
  reg                   rsp_rdzero_r;
  reg                   rsp_drop_r;
  // next values
  reg  [`SAD_DEST_W-1:0] dest_nxt;
  reg  [`SAD_AW-1:0]    addr_nxt;
  reg  [`SAD_BEW-1:0]   be_nxt;
  reg                   xlate_nxt;
  reg                   mabort_nxt;
  reg                   term_nxt;

  wire [9:0]            ap_mask_w = ap_mask(ap_size_r);
  wire [9:0]            ap_base_rd = ap_base_r & ap_mask_w;
  wire [2:0]            ap_size_wr = (cfg_wdata_i[2:0] > `AP_SIZE_MAX) ? `AP_SIZE_MAX
                                                                        : cfg_wdata_i[2:0];

  // config writes
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hole_ctrl_r <= `HOLE_CTRL_RST;
      shadow_e_r  <= `SHADOW_RST;
      shadow_f_r  <= `SHADOW_RST;
      ap_base_r   <= `AP_BASE_RST;
      ap_size_r   <= `AP_SIZE_RST;
    end else if (cfg_wr_i) begin
      case (cfg_addr_i)
        `CFG_HOLE_CTRL: hole_ctrl_r <= cfg_wdata_i;
        `CFG_SHADOW_E:  shadow_e_r  <= cfg_wdata_i;
        `CFG_SHADOW_F:  shadow_f_r  <= cfg_wdata_i;
        `CFG_AP_BASE_LO: ap_base_r[1:0] <= cfg_wdata_i[7:6] & ap_mask_w[1:0];
        `CFG_AP_BASE_HI: ap_base_r[9:2] <= cfg_wdata_i & ap_mask_w[9:2];
        `CFG_AP_SIZE:   ap_size_r   <= ap_size_wr;
        default: ap_size_r <= ap_size_r;
      endcase
    end else if (ap_base_r != ap_base_rd) begin
      // size grew after base was set: keep alignment
      ap_base_r <= ap_base_rd;
    end
  end

  // config reads
  always @* begin
    case (cfg_addr_i)
      `CFG_HOLE_CTRL:  cfg_rdata_nxt = hole_ctrl_r;
      `CFG_SHADOW_E:   cfg_rdata_nxt = shadow_e_r;
      `CFG_SHADOW_F:   cfg_rdata_nxt = shadow_f_r;
      `CFG_AP_BASE_LO: cfg_rdata_nxt = {ap_base_rd[1:0], 6'h00};
      `CFG_AP_BASE_HI: cfg_rdata_nxt = ap_base_rd[9:2];
      `CFG_AP_SIZE:    cfg_rdata_nxt = {5'h00, ap_size_r};
      default:         cfg_rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cfg_rdata_r <= 8'h00;
    else if (cfg_rd_i)
      cfg_rdata_r <= cfg_rdata_nxt;
  end

  // window compares
  wire [`SAD_AW-1:0] a = req_addr_i;
  wire               gfx_mem_hit;
  wire               gfx_pf_hit;
  wire               hubb_mem_hit;
  wire               hubb_pf_hit;

  window_match #(.AW(32)) u_gfx_mem (
    .addr_i  (a[31:0]),
    .base_i  (gfx_mem_window_base_i),
    .limit_i (gfx_mem_window_limit_i),
    .hit_o   (gfx_mem_hit)
  );
  window_match #(.AW(32)) u_gfx_pf (
    .addr_i  (a[31:0]),
    .base_i  (gfx_prefetch_window_base_i),
    .limit_i (gfx_prefetch_window_limit_i),
    .hit_o   (gfx_pf_hit)
  );
  window_match #(.AW(32)) u_hubb_mem (
    .addr_i  (a[31:0]),
    .base_i  (hubb_mem_window_base_i),
    .limit_i (hubb_mem_window_limit_i),
    .hit_o   (hubb_mem_hit)
  );
  window_match #(.AW(32)) u_hubb_pf (
    .addr_i  (a[31:0]),
    .base_i  (hubb_prefetch_window_base_i),
    .limit_i (hubb_prefetch_window_limit_i),
    .hit_o   (hubb_pf_hit)
  );

  // region classification
  wire [`SAD_AW-1:0] mem_top  = {4'h0, top_of_memory_i};
  // 128 KB shifted by select, up to 1 MB
  wire [`SAD_AW-1:0] top_sz   = `TOP_SMRAM_MIN << top_smram_size_i;
  wire [`SAD_AW-1:0] top_lo   = mem_top - top_sz;
  wire               is_cpu   = (req_src_i == `SRC_CPU);
  // smm and write-back qualify only processor requests
  wire               smm_ok   = is_cpu && (req_smm_i || req_wb_i);
  wire [1:0]         eseg_idx = a[`ESEG_SHIFT+1:`ESEG_SHIFT];
  wire               e_re     = shadow_e_r[{eseg_idx, 1'b0}];
  wire               e_we     = shadow_e_r[{eseg_idx, 1'b1}];
  wire               f_re     = shadow_f_r[`SHF_RE_BIT];
  wire               f_we     = shadow_f_r[`SHF_WE_BIT];
  wire               above_4g = (a >= `A_4G);
  wire               in_hole  = hole_ctrl_r[`HOLE_EN_BIT] && in_range(a, `A_HOLE_LO, `A_HOLE_HI);
  wire               in_high  = high_smram_segment_en_i && in_range(a, `A_HIGH_LO, `A_HIGH_HI);
  wire               in_top   = top_smram_segment_en_i && (a >= top_lo) && (a < mem_top);
  wire               in_apic  = in_range(a, `A_APIC_LO, `A_APIC_HI);
  wire               in_ap    = aperture_en_i && !above_4g &&
                                ((a[31:22] & ap_mask_w) == ap_base_rd);
  wire [`SAD_AW-1:0] high_map = a - `A_HIGH_LO + `A_VGA_LO;

  always @* begin
    dest_nxt   = `DEST_HUBA;
    addr_nxt   = a;
    be_nxt     = req_be_i;
    xlate_nxt  = 1'b0;
    mabort_nxt = 1'b0;
    term_nxt   = 1'b0;
    if (above_4g) begin
      dest_nxt = `DEST_TERM;
      term_nxt = 1'b1;
    end else if (a <= `A_DOS_HI) begin
      dest_nxt = `DEST_DRAM;
    end else if (in_range(a, `A_VGA_LO, `A_VGA_HI)) begin
      dest_nxt = (compatible_smram_en_i && is_cpu && req_smm_i) ? `DEST_DRAM : `DEST_HUBA;
    end else if (in_range(a, `A_ESEG_LO, `A_ESEG_HI)) begin
      dest_nxt = ((req_write_i && e_we) || (!req_write_i && e_re)) ? `DEST_DRAM : `DEST_HUBA;
    end else if (in_range(a, `A_FSEG_LO, `A_FSEG_HI)) begin
      dest_nxt = ((req_write_i && f_we) || (!req_write_i && f_re)) ? `DEST_DRAM : `DEST_HUBA;
    end else if (in_hole) begin
      dest_nxt = `DEST_HUBA;
    end else if (in_high || in_top) begin
      if (!is_cpu) begin
        dest_nxt   = `DEST_TERM;
        mabort_nxt = 1'b1;
        term_nxt   = 1'b1;
      end else if (smm_ok) begin
        dest_nxt = `DEST_DRAM;
        // high segment dram never addressed directly
        addr_nxt = in_high ? high_map : a;
      end else begin
        dest_nxt = `DEST_DRAM;
        addr_nxt = `A_ZERO;
        be_nxt   = req_write_i ? {`SAD_BEW{1'b0}} : req_be_i;
      end
    end else if (in_apic) begin
      if (!is_cpu) begin
        dest_nxt   = `DEST_TERM;
        mabort_nxt = !req_write_i;
        term_nxt   = 1'b1;
      end else begin
        dest_nxt = (a > `A_APIC_MID && hubb_en_i) ? `DEST_HUBB : `DEST_HUBA;
      end
    end else if (in_ap) begin
      dest_nxt  = `DEST_DRAM;
      xlate_nxt = 1'b1;
    end else if (gfx_mem_hit || gfx_pf_hit) begin
      dest_nxt = `DEST_GFX;
    end else if (hubb_mem_hit || hubb_pf_hit) begin
      dest_nxt = `DEST_HUBB;
    end else if (a < mem_top) begin
      dest_nxt = `DEST_DRAM;
    end else begin
      dest_nxt = `DEST_HUBA;
    end
  end

  // one cycle decode latency; result holds until next request
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_r  <= 1'b0;
      rsp_dest_r   <= `DEST_HUBA;
      rsp_addr_r   <= `A_ZERO;
      rsp_be_r     <= {`SAD_BEW{1'b0}};
      rsp_xlate_r  <= 1'b0;
      rsp_mabort_r <= 1'b0;
      rsp_rdzero_r <= 1'b0;
      rsp_drop_r   <= 1'b0;
    end else begin
      rsp_valid_r <= req_valid_i;
      if (req_valid_i) begin
        rsp_dest_r   <= dest_nxt;
        rsp_addr_r   <= addr_nxt;
        rsp_be_r     <= be_nxt;
        rsp_xlate_r  <= xlate_nxt;
        rsp_mabort_r <= mabort_nxt;
        rsp_rdzero_r <= term_nxt && !req_write_i;
        rsp_drop_r   <= term_nxt && req_write_i;
      end
    end
  end

  assign cfg_rdata_o  = cfg_rdata_r;
  assign rsp_valid_o  = rsp_valid_r;
  assign rsp_dest_o   = rsp_dest_r;
  assign rsp_addr_o   = rsp_addr_r;
  assign rsp_be_o     = rsp_be_r;
  assign rsp_xlate_o  = rsp_xlate_r;
  assign rsp_mabort_o = rsp_mabort_r;
  assign rsp_rdzero_o = rsp_rdzero_r;
  assign rsp_drop_o   = rsp_drop_r;

endmodule
`default_nettype wire

// *** dv/sad_checker.sv ***
// concurrent checks on the decoder's request and response ports
`timescale 1ns/1ns
`default_nettype none
`include "sad_regs.vh"
module sad_checker (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  // settings
  input  wire logic                   high_smram_segment_en_i,
  input  wire logic                   hubb_en_i,
  // request
  input  wire logic                   req_valid_i,
  input  wire logic [`SAD_AW-1:0]     req_addr_i,
  input  wire logic [1:0]             req_src_i,
  input  wire logic                   req_write_i,
  input  wire logic                   req_smm_i,
  input  wire logic                   req_wb_i,
  input  wire logic [`SAD_BEW-1:0]    req_be_i,
  // response
  input  wire logic                   rsp_valid_o,
  input  wire logic [`SAD_DEST_W-1:0] rsp_dest_o,
  input  wire logic [`SAD_AW-1:0]     rsp_addr_o,
  input  wire logic [`SAD_BEW-1:0]    rsp_be_o,
  input  wire logic                   rsp_mabort_o,
  input  wire logic                   rsp_rdzero_o,
  input  wire logic                   rsp_drop_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire cpu = req_src_i == `SRC_CPU;
  wire hs = req_valid_i && high_smram_segment_en_i && req_addr_i >= `A_HIGH_LO
            && req_addr_i <= `A_HIGH_HI;
  wire ap = req_valid_i && req_addr_i >= `A_APIC_LO && req_addr_i <= `A_APIC_HI;
  wire aplo = req_addr_i <= `A_APIC_MID;
  property p_valid; req_valid_i |=> rsp_valid_o; endproperty
  a_valid: assert property (p_valid)
    else $error("response pulse missing");
  property p_dos;
    req_valid_i && req_addr_i <= `A_DOS_HI
    |=> rsp_dest_o == `DEST_DRAM && rsp_addr_o == $past(req_addr_i);
  endproperty
  a_dos: assert property (p_dos)
    else $error("low memory not sent to dram");
  property p_hi4g;
    req_valid_i && cpu && req_addr_i >= `A_4G |=> rsp_dest_o == `DEST_TERM
    && !rsp_mabort_o && rsp_drop_o == $past(req_write_i) && rsp_rdzero_o != rsp_drop_o;
  endproperty
  a_hi4g: assert property (p_hi4g)
    else $error("access above 4 GB not terminated");
  property p_hs_ok;
    hs && cpu && (req_smm_i || req_wb_i) |=> rsp_dest_o == `DEST_DRAM
    && rsp_addr_o == $past(req_addr_i) - `A_HIGH_LO + `A_VGA_LO;
  endproperty
  a_hs_ok: assert property (p_hs_ok)
    else $error("high smram remap wrong");
  property p_hs_bad;
    hs && cpu && !req_smm_i && !req_wb_i |=> rsp_addr_o == `A_ZERO
    && rsp_be_o == ($past(req_write_i) ? 8'h00 : $past(req_be_i));
  endproperty
  a_hs_bad: assert property (p_hs_bad)
    else $error("invalid high smram access not neutralised");
  property p_hs_src; hs && !cpu |=> rsp_dest_o == `DEST_TERM && rsp_mabort_o; endproperty
  a_hs_src: assert property (p_hs_src)
    else $error("non processor reached high smram");
  property p_apic_lo; ap && cpu && aplo |=> rsp_dest_o == `DEST_HUBA; endproperty
  a_apic_lo: assert property (p_apic_lo)
    else $error("lower apic half not to hub a");
  property p_apic_hi;
    ap && cpu && !aplo |=> rsp_dest_o == ($past(hubb_en_i) ? `DEST_HUBB : `DEST_HUBA);
  endproperty
  a_apic_hi: assert property (p_apic_hi)
    else $error("upper apic half misrouted");
  property p_apic_io;
    ap && !cpu |=> rsp_dest_o == `DEST_TERM && rsp_drop_o == $past(req_write_i)
    && rsp_mabort_o != rsp_drop_o;
  endproperty
  a_apic_io: assert property (p_apic_io)
    else $error("apic access from io agent not refused");
endmodule
bind system_address_decoder sad_checker chk_u (
  .sys_clk_i, .rstn_i, .high_smram_segment_en_i, .hubb_en_i, .req_valid_i, .req_addr_i,
  .req_src_i, .req_write_i, .req_smm_i, .req_wb_i, .req_be_i, .rsp_valid_o, .rsp_dest_o,
  .rsp_addr_o, .rsp_be_o, .rsp_mabort_o, .rsp_rdzero_o, .rsp_drop_o
);
`default_nettype wire

// *** dv/req_initiator.sv ***
// initiator model driving one request per call
`timescale 1ns/1ns
`default_nettype none
module req_initiator (
  // clock
  input  wire logic        sys_clk_i,
  // request
  output var  logic        req_valid_o,
  output var  logic [35:0] req_addr_o,
  output var  logic [1:0]  req_src_o,
  output var  logic        req_write_o,
  output var  logic        req_smm_o,
  output var  logic        req_wb_o,
  output var  logic [7:0]  req_be_o
);
  initial begin
    req_valid_o = 1'b0;
    req_addr_o = 36'h0;
    {req_src_o, req_write_o, req_smm_o, req_wb_o} = 5'h0;
    req_be_o = 8'hFF;
  end
  // mode and write-back flags per request
  task automatic send(input logic [35:0] a, input logic [1:0] s, input logic [2:0] k);
    @(negedge sys_clk_i);
    req_valid_o = 1'b1;
    req_addr_o = a;
    req_src_o = s;
    {req_write_o, req_smm_o, req_wb_o} = k;
    @(negedge sys_clk_i);
    req_valid_o = 1'b0;
    // no bus keeper: released address and flag lines show the inverse, not the last value
    req_addr_o = ~a;
    {req_write_o, req_smm_o, req_wb_o} = ~k;
  endtask
endmodule
`default_nettype wire

// *** dv/system_address_decoder_bench.sv ***
// directed routing and register tests for the system address decoder
`timescale 1ns/1ns
`default_nettype none
`include "sad_regs.vh"
module system_address_decoder_bench;
  localparam [1:0] cpu = `SRC_CPU, hba = `SRC_HUBA, hbb = `SRC_HUBB, gfx = `SRC_GFX;
  localparam [2:0] dr = `DEST_DRAM, ha = `DEST_HUBA, hb = `DEST_HUBB, gx = `DEST_GFX;
  localparam [2:0] tm = `DEST_TERM;
  localparam [35:0] na = 36'hF_FFFF_FFFF;
  logic sys_clk_i, rstn_i, cfg_wr_i, cfg_rd_i, csm, hsm, tsm, hbe, ape;
  logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, rsp_be_o, req_be_i;
  logic [1:0] tsz, req_src_i;
  logic [31:0] mem_top, w [8];
  logic req_valid_i, req_write_i, req_smm_i, req_wb_i, rsp_valid_o, rsp_xlate_o;
  logic rsp_mabort_o, rsp_rdzero_o, rsp_drop_o;
  logic [35:0] req_addr_i, rsp_addr_o;
  logic [2:0] rsp_dest_o;
  int fails = 0, comparisons = 0;
  system_address_decoder dut_u (.sys_clk_i, .rstn_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i,
    .cfg_wdata_i, .cfg_rdata_o, .compatible_smram_en_i(csm), .high_smram_segment_en_i(hsm),
    .top_smram_segment_en_i(tsm), .top_smram_size_i(tsz), .top_of_memory_i(mem_top),
    .hubb_en_i(hbe), .aperture_en_i(ape), .gfx_mem_window_base_i(w[0]),
    .gfx_mem_window_limit_i(w[1]), .gfx_prefetch_window_base_i(w[2]),
    .gfx_prefetch_window_limit_i(w[3]), .hubb_mem_window_base_i(w[4]),
    .hubb_mem_window_limit_i(w[5]), .hubb_prefetch_window_base_i(w[6]),
    .hubb_prefetch_window_limit_i(w[7]), .req_valid_i, .req_addr_i, .req_src_i,
    .req_write_i, .req_smm_i, .req_wb_i, .req_be_i, .rsp_valid_o, .rsp_dest_o, .rsp_addr_o,
    .rsp_be_o, .rsp_xlate_o, .rsp_mabort_o, .rsp_rdzero_o, .rsp_drop_o);
  req_initiator init_u (.sys_clk_i, .req_valid_o(req_valid_i), .req_addr_o(req_addr_i),
    .req_src_o(req_src_i), .req_write_o(req_write_i), .req_smm_o(req_smm_i),
    .req_wb_o(req_wb_i), .req_be_o(req_be_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [35:0] e, input logic [35:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    {cfg_wr_i, cfg_addr_i, cfg_wdata_i} = {1'b1, a, d};
    @(negedge sys_clk_i);
    {cfg_wr_i, cfg_addr_i, cfg_wdata_i} = {1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_i);
    {cfg_rd_i, cfg_addr_i} = {1'b1, a};
    @(negedge sys_clk_i);
    {cfg_rd_i, cfg_addr_i} = {1'b0, ~a};
    chk("cfg_rdata", {28'h0, e}, {28'h0, cfg_rdata_o});
  endtask
  // f: be cleared, xlate, mabort, drop
  task rq(input logic [35:0] a, input logic [1:0] s, input logic [2:0] k,
          input logic [2:0] d, input logic [35:0] ea, input logic [3:0] f);
    init_u.send(a, s, k);
    chk("valid", 36'h1, {35'h0, rsp_valid_o});
    chk("dest", {33'h0, d}, {33'h0, rsp_dest_o});
    if (ea !== na) chk("addr", ea, rsp_addr_o);
    if (d !== tm) chk("be", f[3] ? 36'h0 : 36'hFF, {28'h0, rsp_be_o});
    chk("flags", {33'h0, f[2:0]}, {33'h0, rsp_xlate_o, rsp_mabort_o, rsp_drop_o});
  endtask
  initial begin
    #200_000;
    fails++;
    finish_test;
  end
  initial begin
    {rstn_i, cfg_wr_i, cfg_rd_i, csm, hsm, tsm, hbe, ape, tsz} = 10'h0;
    {cfg_addr_i, cfg_wdata_i} = 16'h0;
    mem_top = 32'h1000_0000;
    // windows placed between top of memory and 4 GB, apart
    for (int i = 0; i < 8; i++) w[i] = 32'hF000_0000 + (i / 2) * 32'h0100_0000 + (i % 2) * 32'h00FF_FFFF;
    repeat (6) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    rd(8'h58, 8'h00);
    rd(8'h59, 8'h00);
    rd(8'h5A, 8'h00);
    rd(8'hB4, 8'h06);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    rq(36'h0_0009_FFFF, hba, 3'h4, dr, 36'h0_0009_FFFF, 4'h0);
    rq(36'h0_000E_0000, cpu, 3'h0, ha, 36'h0_000E_0000, 4'h0);
    rq(36'h0_000F_FFFF, cpu, 3'h4, ha, 36'h0_000F_FFFF, 4'h0);
    wr(8'h5A, 8'h01);
    wr(8'h59, 8'h03);
    rq(36'h0_000E_0000, cpu, 3'h0, dr, 36'h0_000E_0000, 4'h0);
    rq(36'h0_000E_0004, cpu, 3'h4, ha, 36'h0_000E_0004, 4'h0);
    rq(36'h0_000E_4000, cpu, 3'h0, ha, 36'h0_000E_4000, 4'h0);
    rq(36'h0_000F_0000, cpu, 3'h4, dr, 36'h0_000F_0000, 4'h0);
    rq(36'h0_00F0_0000, cpu, 3'h0, dr, 36'h0_00F0_0000, 4'h0);
    wr(8'h58, 8'h80);
    rd(8'h58, 8'h80);
    rq(36'h0_00FF_FFFF, cpu, 3'h0, ha, 36'h0_00FF_FFFF, 4'h0);
    rq(36'h0_0100_0000, cpu, 3'h0, dr, 36'h0_0100_0000, 4'h0);
    csm = 1'b1;
    rq(36'h0_000A_0000, cpu, 3'h2, dr, 36'h0_000A_0000, 4'h0);
    rq(36'h0_000B_FFFF, gfx, 3'h2, ha, 36'h0_000B_FFFF, 4'h0);
    hsm = 1'b1;
    rq(36'h0_FFEA_0010, cpu, 3'h2, dr, 36'h0_000A_0010, 4'h0);
    rq(36'h0_FFEB_FFFF, cpu, 3'h1, dr, 36'h0_000B_FFFF, 4'h0);
    rq(36'h0_FFEA_0020, cpu, 3'h4, dr, 36'h0, 4'h8);
    rq(36'h0_FFEA_0020, cpu, 3'h0, dr, 36'h0, 4'h0);
    rq(36'h0_FFEA_0000, hba, 3'h0, tm, na, 4'h2);
    rq(36'h0_FFEB_0000, gfx, 3'h4, tm, na, 4'h3);
    tsm = 1'b1;
    rq(36'h0_0FFE_0000, cpu, 3'h2, dr, 36'h0_0FFE_0000, 4'h0);
    rq(36'h0_0FFF_FFFF, cpu, 3'h4, dr, 36'h0, 4'h8);
    rq(36'h0_0FFD_FFFF, cpu, 3'h0, dr, 36'h0_0FFD_FFFF, 4'h0);
    rq(36'h0_0FFE_0000, hbb, 3'h0, tm, na, 4'h2);
    tsz = 2'h3;
    rq(36'h0_0FF0_0000, cpu, 3'h0, dr, 36'h0, 4'h0);
    rq(36'h0_0FF0_0000, cpu, 3'h5, dr, 36'h0_0FF0_0000, 4'h0);
    rq(36'h0_FEC7_FFFF, cpu, 3'h0, ha, 36'h0_FEC7_FFFF, 4'h0);
    rq(36'h0_FECF_FFFF, cpu, 3'h0, ha, 36'h0_FECF_FFFF, 4'h0);
    hbe = 1'b1;
    rq(36'h0_FEC8_0000, cpu, 3'h4, hb, 36'h0_FEC8_0000, 4'h0);
    rq(36'h0_FEC0_0000, hbb, 3'h0, tm, na, 4'h2);
    rq(36'h0_FECF_0000, gfx, 3'h4, tm, na, 4'h1);
    rq(36'h0_F0FF_FFFF, cpu, 3'h0, gx, 36'h0_F0FF_FFFF, 4'h0);
    rq(36'h0_F100_0000, hba, 3'h4, gx, 36'h0_F100_0000, 4'h0);
    rq(36'h0_F2FF_FFFF, cpu, 3'h0, hb, 36'h0_F2FF_FFFF, 4'h0);
    rq(36'h0_F300_0000, cpu, 3'h0, hb, 36'h0_F300_0000, 4'h0);
    rq(36'h0_F400_0000, cpu, 3'h0, ha, 36'h0_F400_0000, 4'h0);
    rq(36'h0_E000_0000, cpu, 3'h0, ha, 36'h0_E000_0000, 4'h0);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h00);
    // aperture ends just below the graphics window
    wr(8'h13, 8'hE0);
    ape = 1'b1;
    rq(36'h0_E000_0000, cpu, 3'h0, dr, na, 4'h4);
    rq(36'h0_EFFF_FFFF, gfx, 3'h4, dr, na, 4'h4);
    rq(36'h0_F000_0000, cpu, 3'h0, gx, 36'h0_F000_0000, 4'h0);
    wr(8'hB4, 8'h07);
    rd(8'hB4, 8'h06);
    wr(8'hB4, 8'h00);
    wr(8'h12, 8'hC0);
    rd(8'h12, 8'hC0);
    rq(36'h0_E0FF_FFFF, cpu, 3'h0, dr, na, 4'h4);
    rq(36'h0_E100_0000, cpu, 3'h0, ha, 36'h0_E100_0000, 4'h0);
    rq(36'h1_0000_0000, cpu, 3'h0, tm, na, 4'h0);
    chk("rdzero", 36'h1, {35'h0, rsp_rdzero_o});
    rq(36'h1_0000_0040, cpu, 3'h4, tm, na, 4'h1);
    finish_test;
  end
endmodule
`default_nettype wire
